/* ddc_nco_pkg.sv */
package ddc_nco_pkg;
  localparam int NUM_PRESETS = 4;
  localparam int PRESET_W = 2;
  localparam int ADDR_W = 12;
  // register map, one aligned word each
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;
  localparam logic [11:0] TUNING_BASE = 12'h100;
  localparam logic [11:0] PHASE_BASE = 12'h200;
  localparam logic [11:0] DELAY_BASE = 12'h300;
  // field positions
  localparam int CTRL_DECIM_LSB = 8;
  localparam int CTRL_DECIM_W = 6;
  localparam int STATUS_BYPASS_BIT = 0;
  localparam int STATUS_ILLEGAL_BIT = 1;
  // reset values
  localparam logic [31:0] TUNING_RST = 32'hc0000000;
  localparam logic [15:0] PHASE_RST = 16'h0000;
  localparam logic [7:0] DELAY_RST = 8'hff;
  localparam logic [7:0] DELAY_BYPASS = 8'hff;
  localparam logic [5:0] DECIM_RST = 6'h04;
  localparam logic [5:0] DECIM_MIN = 6'h04;
  localparam logic [5:0] DECIM_MAX = 6'h20;
  // data path
  localparam int SAMPLE_W = 15;
  localparam int FILTER_LATENCY = 34;
  localparam int DELAY_LINE_LEN = 64;
endpackage

/* ddc_nco_phase_and_fractional_delay.sv */
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
// Overview of operation
// - the 16-bit phase offset forms the top half of a 32-bit word added to the accumulator.
// - the phase offset in radians is the programmed value times 2^-16 times two pi.
// - the offset wraps modulo one cycle so signed and unsigned readings give one phase.
// - the 8-bit fine delay moves group delay in half input-sample steps.
// - fine delay 0xff, its reset value, bypasses the filter and saves 34 input samples.
// - output samples are a 15-bit in-phase and a 15-bit quadrature word.
// - decimation factors from 4 to 32 are supported; here the factor only sets the fine delay limit, the output is not decimated.
// - the accumulator advances by the tuning word each input sample.
module ddc_nco_phase_and_fractional_delay (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic sample_valid_in,
  input wire logic [14:0] sample_in,
  output logic [14:0] i_out,
  output logic [14:0] q_out,
  output logic iq_valid_out,
  output logic [31:0] phase_out
);

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [31:0] tuning_q [ddc_nco_pkg::NUM_PRESETS];
  logic [31:0] tuning_d [ddc_nco_pkg::NUM_PRESETS];
  logic [15:0] phase_q [ddc_nco_pkg::NUM_PRESETS];
  logic [15:0] phase_d [ddc_nco_pkg::NUM_PRESETS];
  logic [7:0] delay_q [ddc_nco_pkg::NUM_PRESETS];
  logic [7:0] delay_d [ddc_nco_pkg::NUM_PRESETS];
  logic [1:0] preset_q, preset_d;
  logic [5:0] decim_q, decim_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic access_w;
  logic [1:0] idx_w;
  logic [11:0] base_w;
  logic bypass_w;
  logic illegal_w;
  logic [8:0] limit_w;

  assign access_w = psel_in && penable_in && !pready_q;
  assign idx_w = paddr_in[3:2];
  assign base_w = {paddr_in[11:4], 4'h0};
  assign bypass_w = delay_q[preset_q] == ddc_nco_pkg::DELAY_BYPASS;
  assign limit_w = {2'b00, decim_q, 1'b0};
  // setting beyond 2D-1 flagged for software
  assign illegal_w = !bypass_w && ({1'b0, delay_q[preset_q]} >= limit_w);

  always_comb begin
    tuning_d = tuning_q;
    phase_d = phase_q;
    delay_d = delay_q;
    preset_d = preset_q;
    decim_d = decim_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    pready_d = access_w;
    if (access_w) begin
      prdata_d = 32'h00000000;
      if (paddr_in[1:0] != 2'b00) begin
        pslverr_d = 1'b1;
      end else if (paddr_in == ddc_nco_pkg::CTRL_ADDR) begin
        if (pwrite_in) begin
          preset_d = pwdata_in[1:0];
          if (pwdata_in[13:8] >= ddc_nco_pkg::DECIM_MIN &&
              pwdata_in[13:8] <= ddc_nco_pkg::DECIM_MAX) begin
            decim_d = pwdata_in[13:8];
          end
        end
        prdata_d = {18'h00000, decim_q, 6'h00, preset_q};
      end else if (paddr_in == ddc_nco_pkg::STATUS_ADDR) begin
        prdata_d = {30'h00000000, illegal_w, bypass_w};
      end else if (base_w == ddc_nco_pkg::TUNING_BASE) begin
        if (pwrite_in) begin
          tuning_d[idx_w] = pwdata_in;
        end
        prdata_d = tuning_q[idx_w];
      end else if (base_w == ddc_nco_pkg::PHASE_BASE) begin
        if (pwrite_in) begin
          phase_d[idx_w] = pwdata_in[15:0];
        end
        prdata_d = {16'h0000, phase_q[idx_w]};
      end else if (base_w == ddc_nco_pkg::DELAY_BASE) begin
        if (pwrite_in) begin
          delay_d[idx_w] = pwdata_in[7:0];
        end
        prdata_d = {24'h000000, delay_q[idx_w]};
      end else begin
        pslverr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int k = 0; k < ddc_nco_pkg::NUM_PRESETS; k++) begin
        tuning_q[k] <= ddc_nco_pkg::TUNING_RST;
        phase_q[k] <= ddc_nco_pkg::PHASE_RST;
        delay_q[k] <= ddc_nco_pkg::DELAY_RST;
      end
      preset_q <= 2'b00;
      decim_q <= ddc_nco_pkg::DECIM_RST;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      tuning_q <= tuning_d;
      phase_q <= phase_d;
      delay_q <= delay_d;
      preset_q <= preset_d;
      decim_q <= decim_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // oscillator
  logic [31:0] acc_q, acc_d;
  logic [31:0] phase_sum_q, phase_sum_d;

  always_comb begin
    acc_d = acc_q;
    phase_sum_d = phase_sum_q;
    if (sample_valid_in) begin
      acc_d = acc_q + tuning_q[preset_q];
      // modulo 2^32 add: value times 2^-16 of a cycle
      phase_sum_d = acc_q + {phase_q[preset_q], 16'h0000};
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc_q <= 32'h00000000;
      phase_sum_q <= 32'h00000000;
    end else begin
      acc_q <= acc_d;
      phase_sum_q <= phase_sum_d;
    end
  end

  assign phase_out = phase_sum_q;

  ////////////////////////////////////////////////////////////////////////////
  // mixer: quarter-cycle rotation from the top two phase bits
  logic [14:0] mix_i_q, mix_i_d;
  logic [14:0] mix_q_q, mix_q_d;
  logic mix_v_q, mix_v_d;
  logic [14:0] neg_w;

  assign neg_w = 15'h0000 - sample_in;

  always_comb begin
    mix_v_d = sample_valid_in;
    mix_i_d = mix_i_q;
    mix_q_d = mix_q_q;
    if (sample_valid_in) begin
      unique case (phase_sum_d[31:30])
        2'b00: begin
          mix_i_d = sample_in;
          mix_q_d = 15'h0000;
        end
        2'b01: begin
          mix_i_d = 15'h0000;
          mix_q_d = neg_w;
        end
        2'b10: begin
          mix_i_d = neg_w;
          mix_q_d = 15'h0000;
        end
        2'b11: begin
          mix_i_d = 15'h0000;
          mix_q_d = sample_in;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mix_i_q <= 15'h0000;
      mix_q_q <= 15'h0000;
      mix_v_q <= 1'b0;
    end else begin
      mix_i_q <= mix_i_d;
      mix_q_q <= mix_q_d;
      mix_v_q <= mix_v_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fractional delay line, half-sample steps as two-tap average
  logic [29:0] line_q [ddc_nco_pkg::DELAY_LINE_LEN];
  logic [29:0] line_d [ddc_nco_pkg::DELAY_LINE_LEN];
  logic [14:0] out_i_q, out_i_d;
  logic [14:0] out_q_q, out_q_d;
  logic out_v_q, out_v_d;
  logic [5:0] tap_w;
  logic [29:0] tap_a_w, tap_b_w;
  logic [15:0] avg_i_w, avg_q_w;

  // whole samples from delay bits 5:1 (delay/2 modulo 32) plus fixed filter latency
  // line_q[0] already lags the mixer by one sample, so the tap is one less
  assign tap_w = 6'(ddc_nco_pkg::FILTER_LATENCY - 1)
               + {1'b0, delay_q[preset_q][5:1]};
  assign tap_a_w = line_q[tap_w];
  assign tap_b_w = line_q[6'(tap_w + 6'h01)];
  assign avg_i_w = {tap_a_w[29], tap_a_w[29:15]} + {tap_b_w[29], tap_b_w[29:15]};
  assign avg_q_w = {tap_a_w[14], tap_a_w[14:0]} + {tap_b_w[14], tap_b_w[14:0]};

  always_comb begin
    line_d = line_q;
    out_v_d = mix_v_q;
    out_i_d = out_i_q;
    out_q_d = out_q_q;
    if (mix_v_q) begin
      line_d[0] = {mix_i_q, mix_q_q};
      for (int k = 1; k < ddc_nco_pkg::DELAY_LINE_LEN; k++) begin
        line_d[k] = line_q[k-1];
      end
      if (bypass_w) begin
        out_i_d = mix_i_q;
        out_q_d = mix_q_q;
      end else if (delay_q[preset_q][0]) begin
        out_i_d = avg_i_w[15:1];
        out_q_d = avg_q_w[15:1];
      end else begin
        out_i_d = tap_a_w[29:15];
        out_q_d = tap_a_w[14:0];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int k = 0; k < ddc_nco_pkg::DELAY_LINE_LEN; k++) begin
        line_q[k] <= 30'h00000000;
      end
      out_i_q <= 15'h0000;
      out_q_q <= 15'h0000;
      out_v_q <= 1'b0;
    end else begin
      line_q <= line_d;
      out_i_q <= out_i_d;
      out_q_q <= out_q_d;
      out_v_q <= out_v_d;
    end
  end

  // 15-bit in-phase and quadrature words
  assign i_out = out_i_q;
  assign q_out = out_q_q;
  assign iq_valid_out = out_v_q;

endmodule

/* ddc_checker_assertions.sv */
`timescale 1ns/100ps
module ddc_checker (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic sample_valid_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic iq_valid_out,
  input wire logic [14:0] i_out,
  input wire logic [14:0] q_out,
  input wire logic [31:0] phase_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence acc_wait;
    psel_in && penable_in && !pready_out;
  endsequence
  sequence quiet;
    (!sample_valid_in && !psel_in)[*3];
  endsequence
  a_iq_lat: assert property (sample_valid_in |-> ##2 iq_valid_out)
    else $error("iq valid late");
  a_iq_cause: assert property (iq_valid_out |-> $past(sample_valid_in, 2))
    else $error("iq valid without sample");
  a_iq_hold: assert property (!iq_valid_out |-> $stable({i_out, q_out}))
    else $error("iq moved while idle");
  a_rdy_wait: assert property (acc_wait |=> pready_out)
    else $error("no ready after wait state");
  a_rdy_once: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  a_rdy_cause: assert property (pready_out |-> $past(psel_in && penable_in))
    else $error("ready without access");
  a_err_rdy: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  a_ph_still: assert property (quiet |=> $stable(phase_out))
    else $error("phase moved without sample");
endmodule
bind ddc_nco_phase_and_fractional_delay ddc_checker ddc_checker_i (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .sample_valid_in(sample_valid_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .iq_valid_out(iq_valid_out), .i_out(i_out),
  .q_out(q_out), .phase_out(phase_out));

/* link_capture_model.sv */
`timescale 1ns/100ps
module link_capture_model (
  input wire logic clk_in,
  input wire logic [14:0] i_in,
  input wire logic [14:0] q_in,
  input wire logic valid_in,
  output logic [29:0] pair_out,
  output logic got_out
);
  // takes one i/q pair per valid cycle
  always_ff @(posedge clk_in) begin
    got_out <= valid_in;
    if (valid_in) begin
      pair_out <= {i_in, q_in};
    end
  end
endmodule

/* ddc_nco_phase_and_fractional_delay_bench.sv */
`timescale 1ns/100ps
module ddc_nco_phase_and_fractional_delay_bench;
  logic sys_clk_in = 0, reset_n_in = 0, psel = 0, pen = 0, pwr = 0, sv = 0;
  logic pready, perr, iqv, got;
  logic [11:0] pa = 0, o;
  logic [31:0] pwd = 0, prd, ph, a, rs = 32'd53117;
  logic [14:0] si = 0, io, qo;
  logic [29:0] cap;
  logic [33:0] e, aq[$];
  logic [30:0] s, sq[$];
  int miscompares = 0, comparisons = 0;
  ddc_nco_phase_and_fractional_delay ddc_nco_phase_and_fractional_delay_i (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(pready),
    .pslverr_out(perr), .sample_valid_in(sv), .sample_in(si), .i_out(io), .q_out(qo),
    .iq_valid_out(iqv), .phase_out(ph));
  link_capture_model link_capture_model_i (.clk_in(sys_clk_in), .i_in(io), .q_in(qo),
    .valid_in(iqv), .pair_out(cap), .got_out(got));
  always #5 sys_clk_in = ~sys_clk_in;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] y);
    comparisons++;
    if (y !== x) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, x, y);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // apb transfer; x = {check data, error, data}
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
                     input logic [33:0] x);
    aq.push_back(x);
    pa <= ad;
    pwr <= w;
    pwd <= d;
    psel <= 1;
    @(posedge sys_clk_in) pen <= 1;
    for (int k = 0; k < 20 && pready !== 1; k++) @(posedge sys_clk_in);
    if (pready !== 1) miscompares++;
    if (pready !== 1) report_and_stop;
    psel <= 0;
    pen <= 0;
    @(posedge sys_clk_in);
  endtask
  // n samples back to back, output expected from k samples earlier
  task automatic smpl(input int n, input int k, input logic neg);
    logic [14:0] v[$];
    logic [14:0] x, y;
    for (int j = 0; j < n; j++) begin
      rs = xs(rs);
      x = {rs[13], rs[13:0]};
      v.push_back(x);
      y = (j >= k) ? v[j - k] : 15'h0;
      sq.push_back({j >= k, neg ? -y : y, 15'h0});
      si <= x;
      sv <= 1;
      @(posedge sys_clk_in);
    end
    sv <= 0;
    repeat (4) @(posedge sys_clk_in);
  endtask
  always @(posedge sys_clk_in) begin
    if (psel && pen && pready === 1) begin
      e = aq.pop_front();
      chk("pslverr", {31'h0, e[32]}, {31'h0, perr});
      if (e[33]) chk("prdata", e[31:0], prd);
    end
    if (got === 1) begin
      s = sq.pop_front();
      if (s[30]) chk("iq", {2'h0, s[29:0]}, {2'h0, cap});
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk_in);
    reset_n_in <= 1;
    for (int p = 0; p < 4; p++) begin
      o = 12'(4 * p);
      apb(0, ddc_nco_pkg::TUNING_BASE + o, 0, {2'b10, ddc_nco_pkg::TUNING_RST});
      apb(0, ddc_nco_pkg::PHASE_BASE + o, 0, {18'h20000, ddc_nco_pkg::PHASE_RST});
      apb(0, ddc_nco_pkg::DELAY_BASE + o, 0, {26'h2000000, ddc_nco_pkg::DELAY_RST});
    end
    apb(0, ddc_nco_pkg::STATUS_ADDR, 0, {2'b10, 32'h1});
    apb(0, 12'h400, 0, {2'b11, 32'h0});
    apb(1, ddc_nco_pkg::CTRL_ADDR, 32'h2000, 34'h0);
    apb(1, ddc_nco_pkg::CTRL_ADDR, 32'h2100, 34'h0);
    apb(0, ddc_nco_pkg::CTRL_ADDR, 0, {2'b10, 32'h2000});
    $display("registers done");
    apb(1, ddc_nco_pkg::TUNING_BASE, 0, 34'h0);
    smpl(12, 0, 0);
    apb(1, ddc_nco_pkg::PHASE_BASE, 32'h8000, 34'h0);
    smpl(12, 0, 1);
    apb(1, ddc_nco_pkg::PHASE_BASE, 0, 34'h0);
    apb(1, ddc_nco_pkg::DELAY_BASE, 0, 34'h0);
    apb(0, ddc_nco_pkg::STATUS_ADDR, 0, {2'b10, 32'h0});
    smpl(40, 34, 0);
    apb(1, ddc_nco_pkg::DELAY_BASE, 2, 34'h0);
    smpl(40, 35, 0);
    apb(1, ddc_nco_pkg::DELAY_BASE, 32'h40, 34'h0);
    apb(0, ddc_nco_pkg::STATUS_ADDR, 0, {2'b10, 32'h2});
    apb(1, ddc_nco_pkg::TUNING_BASE + 12'h4, 0, 34'h0);
    apb(1, ddc_nco_pkg::PHASE_BASE + 12'h4, 32'h8000, 34'h0);
    apb(1, ddc_nco_pkg::CTRL_ADDR, 32'h2001, 34'h0);
    smpl(12, 0, 1);
    apb(1, ddc_nco_pkg::CTRL_ADDR, 32'h2000, 34'h0);
    $display("stream done");
    apb(1, ddc_nco_pkg::TUNING_BASE, 32'h01234567, 34'h0);
    smpl(1, 999, 0);
    a = ph;
    smpl(1, 999, 0);
    chk("phase step", 32'h01234567, ph - a);
    a = ph;
    apb(1, ddc_nco_pkg::PHASE_BASE, 32'hffff, 34'h0);
    smpl(1, 999, 0);
    chk("phase offset", 32'h01234567 + 32'hffff0000, ph - a);
    $display("phase done");
    report_and_stop;
  end
endmodule
